// ==== common/reg_pkg.sv ====
package reg_pkg;

  // register indices on the serial register port
  localparam logic [7:0] OFS_COMMAND = 8'h03;
  localparam logic [7:0] OFS_STREAM = 8'h05;
  localparam logic [7:0] OFS_STATUS = 8'h06;
  localparam logic [7:0] OFS_BIT_RATE = 8'h07;
  localparam logic [7:0] OFS_IRQ_ENABLE = 8'h08;
  localparam logic [7:0] OFS_IRQ_POLICY = 8'h09;
  localparam logic [7:0] OFS_SLEEP = 8'h0a;
  localparam logic [7:0] OFS_PART_CODE = 8'h10;
  localparam logic [7:0] OFS_SW_RELEASE = 8'h11;
  localparam logic [7:0] OFS_TOP_RATE = 8'h12;
  localparam logic [7:0] OFS_FIFO_FILL = 8'he9;

  // status and enable bit positions (shared layout)
  localparam int BIT_CREATED = 0;
  localparam int BIT_ACTIVATED = 1;
  localparam int BIT_DATA_READY = 8;
  localparam int ERR_LSB = 16;
  localparam int ERR_W = 6;
  localparam int ERR_GENERAL = 0;
  localparam int ERR_BAD_CMD = 1;
  localparam int ERR_BAD_MODE = 2;
  localparam int ERR_CREATE = 3;
  localparam int ERR_ACTIVATE = 4;
  localparam int ERR_WRONG_STATE = 5;

  localparam logic [31:0] KEEP_GROUP = 32'h0000_00ff;
  localparam logic [31:0] CLEAR_GROUP = 32'hffff_f000;
  localparam logic [31:0] NO_IRQ = 32'h0000_0000;

  // setting codes
  localparam logic [31:0] STREAM_OFF = 32'h0000_0000;
  localparam logic [31:0] STREAM_ON = 32'h0000_0001;
  localparam logic [31:0] PIN_QUIET = 32'h0000_0000;
  localparam logic [31:0] PIN_FOLLOW = 32'h0000_0001;
  localparam logic [31:0] CMD_CLEAR_STATUS = 32'h0000_0004;

  // reset values
  localparam logic [31:0] BIT_RATE_RESET = 32'h0001_c200;
  localparam logic [31:0] ZERO_RESET = 32'h0000_0000;

  // identity and release defaults, values arbitrary
  localparam logic [31:0] PART_CODE_DEFAULT = 32'h0000_5a3c;
  localparam logic [7:0] REL_MAJOR_DEFAULT = 8'h01;
  localparam logic [7:0] REL_MINOR_DEFAULT = 8'h00;
  localparam logic [7:0] REL_PATCH_DEFAULT = 8'h00;
  localparam logic [31:0] TOP_RATE_DEFAULT = 32'h0003_8400;

endpackage

// ==== core/cfg_word.sv ====
`timescale 1ns/1ps
module cfg_word #(
  parameter logic [31:0] RESET_VALUE = 32'h0000_0000
) (
  input wire logic mclk_i, // clock
  input wire logic reset_n_i, // async reset, active low
  input wire logic load_i, // store data_i this cycle
  input wire logic [31:0] data_i, // value to store
  output logic [31:0] value_o // stored value
);

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      value_o <= RESET_VALUE;
    end else if (load_i) begin
      value_o <= data_i;
    end
  end

endmodule

// ==== core/sticky_flags.sv ====
`timescale 1ns/1ps
module sticky_flags #(
  parameter int WIDTH = 6
) (
  input wire logic mclk_i, // clock
  input wire logic reset_n_i, // async reset, active low
  input wire logic [WIDTH-1:0] set_i, // event pulses
  input wire logic clear_i, // clear all flags
  output logic [WIDTH-1:0] flags_o // sticky flags
);

  // a set in the clear cycle survives the clear
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      flags_o <= '0;
    end else begin
      flags_o <= (flags_o & ~{WIDTH{clear_i}}) | set_i;
    end
  end

endmodule

// ==== core/module_status_irq_regs.sv ====
`timescale 1ns/1ps
module module_status_irq_regs #(
  parameter logic [31:0] PART_CODE = reg_pkg::PART_CODE_DEFAULT,
  parameter logic [7:0] REL_MAJOR = reg_pkg::REL_MAJOR_DEFAULT,
  parameter logic [7:0] REL_MINOR = reg_pkg::REL_MINOR_DEFAULT,
  parameter logic [7:0] REL_PATCH = reg_pkg::REL_PATCH_DEFAULT,
  parameter logic [31:0] TOP_RATE = reg_pkg::TOP_RATE_DEFAULT
) (
  input wire logic mclk_i, // 40 MHz clock
  input wire logic reset_n_i, // async reset, active low
  input wire logic reg_wr_i, // register write strobe
  input wire logic reg_rd_i, // register read strobe
  input wire logic [7:0] reg_addr_i, // register index
  input wire logic [31:0] reg_wdata_i, // write data
  output logic [31:0] reg_rdata_o, // read data
  output logic reg_rvalid_o, // read data valid pulse
  input wire logic buf_rd_i, // host buffer read strobe
  input wire logic access_ok_i, // module state permits access
  input wire logic svc_created_i, // service exists, level
  input wire logic svc_active_i, // service running, level
  input wire logic data_ready_i, // result data waiting, level
  input wire logic err_general_i, // module error pulse
  input wire logic err_bad_cmd_i, // invalid command pulse
  input wire logic err_bad_mode_i, // invalid mode pulse
  input wire logic err_create_i, // create failure pulse
  input wire logic err_activate_i, // activate failure pulse
  input wire logic [31:0] fifo_fill_i, // result buffer fill
  output logic stream_en_o, // serial streaming enabled
  output logic [31:0] serial_bit_rate_o, // selected bit rate
  output logic [31:0] sleep_setting_o, // module sleep setting
  output logic cmd_valid_o, // command pulse
  output logic [31:0] cmd_code_o, // command code
  output logic [31:0] status_o, // live status word
  output logic mcu_int_o // host interrupt pin, active high
);

  localparam int ERR_W_L = reg_pkg::ERR_W;

  logic [31:0] stream_word;
  logic [31:0] irq_enable_bits;
  logic [31:0] irq_pin_policy;
  logic [ERR_W_L-1:0] err_flags;
  logic [31:0] status_word;
  logic [31:0] next_rdata;
  logic [ERR_W_L-1:0] err_set;

  // address decode
  wire hit_cmd = reg_addr_i == reg_pkg::OFS_COMMAND;
  wire hit_stream = reg_addr_i == reg_pkg::OFS_STREAM;
  wire hit_rate = reg_addr_i == reg_pkg::OFS_BIT_RATE;
  wire hit_enable = reg_addr_i == reg_pkg::OFS_IRQ_ENABLE;
  wire hit_policy = reg_addr_i == reg_pkg::OFS_IRQ_POLICY;
  wire hit_sleep = reg_addr_i == reg_pkg::OFS_SLEEP;
  wire hit_rw = hit_stream | hit_rate | hit_enable | hit_policy | hit_sleep;

  // writable settings are only taken in a permitting state
  wire wr_ok = reg_wr_i & access_ok_i;
  wire wr_refused = reg_wr_i & hit_rw & ~access_ok_i;
  wire buf_refused = buf_rd_i & ~access_ok_i;

  // value checks; an out-of-range value is dropped and flagged
  wire stream_val_ok = (reg_wdata_i == reg_pkg::STREAM_OFF) |
                       (reg_wdata_i == reg_pkg::STREAM_ON);
  wire policy_val_ok = (reg_wdata_i == reg_pkg::PIN_QUIET) |
                       (reg_wdata_i == reg_pkg::PIN_FOLLOW);
  // rates above the reported maximum would not be generated reliably
  wire rate_val_ok = (reg_wdata_i != reg_pkg::ZERO_RESET) &
                     (reg_wdata_i <= TOP_RATE);

  wire load_stream = wr_ok & hit_stream & stream_val_ok;
  wire load_rate = wr_ok & hit_rate & rate_val_ok;
  wire load_enable = wr_ok & hit_enable;
  wire load_policy = wr_ok & hit_policy & policy_val_ok;
  wire load_sleep = wr_ok & hit_sleep;

  wire bad_value = wr_ok & ((hit_stream & ~stream_val_ok) |
                            (hit_policy & ~policy_val_ok) |
                            (hit_rate & ~rate_val_ok));

  // commands are accepted in every state
  wire wr_cmd = reg_wr_i & hit_cmd;
  wire clear_status = wr_cmd & (reg_wdata_i == reg_pkg::CMD_CLEAR_STATUS);
  wire pass_cmd = wr_cmd & ~clear_status;

  cfg_word #(
    .RESET_VALUE(reg_pkg::STREAM_OFF)
  ) u_stream (
    .mclk_i(mclk_i),
    .reset_n_i(reset_n_i),
    .load_i(load_stream),
    .data_i(reg_wdata_i),
    .value_o(stream_word)
  );

  cfg_word #(
    .RESET_VALUE(reg_pkg::BIT_RATE_RESET)
  ) u_rate (
    .mclk_i(mclk_i),
    .reset_n_i(reset_n_i),
    .load_i(load_rate),
    .data_i(reg_wdata_i),
    .value_o(serial_bit_rate_o)
  );

  cfg_word #(
    .RESET_VALUE(reg_pkg::NO_IRQ)
  ) u_enable (
    .mclk_i(mclk_i),
    .reset_n_i(reset_n_i),
    .load_i(load_enable),
    .data_i(reg_wdata_i),
    .value_o(irq_enable_bits)
  );

  cfg_word #(
    .RESET_VALUE(reg_pkg::PIN_QUIET)
  ) u_policy (
    .mclk_i(mclk_i),
    .reset_n_i(reset_n_i),
    .load_i(load_policy),
    .data_i(reg_wdata_i),
    .value_o(irq_pin_policy)
  );

  cfg_word #(
    .RESET_VALUE(reg_pkg::ZERO_RESET)
  ) u_sleep (
    .mclk_i(mclk_i),
    .reset_n_i(reset_n_i),
    .load_i(load_sleep),
    .data_i(reg_wdata_i),
    .value_o(sleep_setting_o)
  );

  // error events into the sticky group
  always_comb begin
    err_set = '0;
    err_set[reg_pkg::ERR_GENERAL] = err_general_i;
    err_set[reg_pkg::ERR_BAD_CMD] = err_bad_cmd_i | bad_value;
    err_set[reg_pkg::ERR_BAD_MODE] = err_bad_mode_i;
    err_set[reg_pkg::ERR_CREATE] = err_create_i;
    err_set[reg_pkg::ERR_ACTIVATE] = err_activate_i;
    err_set[reg_pkg::ERR_WRONG_STATE] = wr_refused | buf_refused;
  end

  sticky_flags #(
    .WIDTH(ERR_W_L)
  ) u_errors (
    .mclk_i(mclk_i),
    .reset_n_i(reset_n_i),
    .set_i(err_set),
    .clear_i(clear_status),
    .flags_o(err_flags)
  );

  // low group tracks the live levels and has no clear path
  always_comb begin
    status_word = reg_pkg::ZERO_RESET;
    status_word[reg_pkg::BIT_CREATED] = svc_created_i;
    status_word[reg_pkg::BIT_ACTIVATED] = svc_active_i;
    status_word[reg_pkg::BIT_DATA_READY] = data_ready_i;
    status_word[reg_pkg::ERR_LSB +: ERR_W_L] = err_flags;
  end

  // enable bits share the status layout, so an or-reduce of the masked status suffices
  wire irq_live = |(status_word & irq_enable_bits);
  wire pin_follow = irq_pin_policy == reg_pkg::PIN_FOLLOW;

  wire [31:0] release_word = {8'h00, REL_MAJOR, REL_MINOR, REL_PATCH};

  // read mux; read-only words other than status come from parameters and inputs only
  always_comb begin
    case (reg_addr_i)
      reg_pkg::OFS_STREAM: next_rdata = stream_word;
      reg_pkg::OFS_STATUS: next_rdata = status_word;
      reg_pkg::OFS_BIT_RATE: next_rdata = serial_bit_rate_o;
      reg_pkg::OFS_IRQ_ENABLE: next_rdata = irq_enable_bits;
      reg_pkg::OFS_IRQ_POLICY: next_rdata = irq_pin_policy;
      reg_pkg::OFS_SLEEP: next_rdata = sleep_setting_o;
      reg_pkg::OFS_PART_CODE: next_rdata = PART_CODE;
      reg_pkg::OFS_SW_RELEASE: next_rdata = release_word;
      reg_pkg::OFS_TOP_RATE: next_rdata = TOP_RATE;
      reg_pkg::OFS_FIFO_FILL: next_rdata = fifo_fill_i;
      default: next_rdata = reg_pkg::ZERO_RESET;
    endcase
  end

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      reg_rdata_o <= reg_pkg::ZERO_RESET;
      reg_rvalid_o <= 1'b0;
    end else begin
      reg_rvalid_o <= reg_rd_i;
      if (reg_rd_i) begin
        reg_rdata_o <= next_rdata;
      end
    end
  end

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      stream_en_o <= 1'b0;
      mcu_int_o <= 1'b0;
      status_o <= reg_pkg::ZERO_RESET;
    end else begin
      stream_en_o <= stream_word == reg_pkg::STREAM_ON;
      mcu_int_o <= pin_follow & irq_live;
      status_o <= status_word;
    end
  end

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cmd_valid_o <= 1'b0;
      cmd_code_o <= reg_pkg::ZERO_RESET;
    end else begin
      cmd_valid_o <= pass_cmd;
      if (pass_cmd) begin
        cmd_code_o <= reg_wdata_i;
      end
    end
  end

endmodule

// ==== tb/host_mcu.sv ====
`timescale 1ns/1ps
module host_mcu (
  input wire logic mclk_i, // clock
  output logic reg_wr_o, // write strobe
  output logic reg_rd_o, // read strobe
  output logic [7:0] reg_addr_o, // register index
  output logic [31:0] reg_wdata_o, // write data
  input wire logic [31:0] reg_rdata_i, // read data
  input wire logic reg_rvalid_i // read data valid
);
  initial begin
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
    reg_addr_o = 8'h00;
    reg_wdata_o = 32'h0000_0000;
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    reg_wr_o <= 1'b1;
    reg_addr_o <= a;
    reg_wdata_o <= d;
    @(posedge mclk_i);
    reg_wr_o <= 1'b0;
    // stale data is inverted so a late sample never matches
    reg_wdata_o <= ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge mclk_i);
    reg_rd_o <= 1'b1;
    reg_addr_o <= a;
    @(posedge mclk_i);
    reg_rd_o <= 1'b0;
    #1;
    d = reg_rvalid_i ? reg_rdata_i : 32'hxxxx_xxxx;
  endtask
endmodule

// ==== tb/status_irq_chk.sv ====
`timescale 1ns/1ps
module status_irq_chk #(
  parameter logic [31:0] TOP_RATE = 32'h0000_0000,
  parameter logic [7:0] REL_MAJOR = 8'h00,
  parameter logic [7:0] REL_MINOR = 8'h00,
  parameter logic [7:0] REL_PATCH = 8'h00
) (
  input wire logic mclk_i, // clock
  input wire logic reset_n_i, // reset
  input wire logic reg_wr_i, // write strobe
  input wire logic reg_rd_i, // read strobe
  input wire logic [7:0] reg_addr_i, // index
  input wire logic [31:0] reg_wdata_i, // write data
  input wire logic [31:0] reg_rdata_o, // read data
  input wire logic reg_rvalid_o, // read valid
  input wire logic access_ok_i, // access allowed
  input wire logic data_ready_i, // data waiting
  input wire logic err_general_i, // error pulse
  input wire logic [31:0] fifo_fill_i, // fill count
  input wire logic stream_en_o, // streaming
  input wire logic [31:0] serial_bit_rate_o, // bit rate
  input wire logic [31:0] status_o, // status copy
  input wire logic mcu_int_o // host pin
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!reset_n_i);
  sequence s_rd(a); reg_rd_i && reg_addr_i == a; endsequence
  sequence s_wr(a); reg_wr_i && reg_addr_i == a && access_ok_i; endsequence
  property p_fill; s_rd(8'he9) |=> reg_rvalid_o && reg_rdata_o == $past(fifo_fill_i); endproperty
  a_fill: assert property (p_fill) else $error("fill read wrong");
  property p_top; s_rd(8'h12) |=> reg_rdata_o == TOP_RATE; endproperty
  a_top: assert property (p_top) else $error("top rate read wrong");
  property p_rel; s_rd(8'h11) |=> reg_rdata_o == {8'h00, REL_MAJOR, REL_MINOR, REL_PATCH}; endproperty
  a_rel: assert property (p_rel) else $error("release read wrong");
  property p_live; $past(reset_n_i) |-> status_o[8] == $past(data_ready_i); endproperty
  a_live: assert property (p_live) else $error("ready bit not live");
  property p_err; err_general_i |-> ##2 status_o[16]; endproperty
  a_err: assert property (p_err) else $error("error bit not set");
  property p_sticky;
    $fell(status_o[16]) |-> $past(reg_wr_i && reg_addr_i == 8'h03 && reg_wdata_i == 32'h4, 2);
  endproperty
  a_sticky: assert property (p_sticky) else $error("error bit dropped");
  property p_wrong; reg_wr_i && reg_addr_i == 8'h05 && !access_ok_i |-> ##2 status_o[21]; endproperty
  a_wrong: assert property (p_wrong) else $error("wrong state not flagged");
  property p_stream; s_wr(8'h05) ##0 reg_wdata_i == 32'h1 |-> ##2 stream_en_o; endproperty
  a_stream: assert property (p_stream) else $error("streaming not on");
  property p_bad; s_wr(8'h05) ##0 reg_wdata_i > 32'h1 |-> ##2 status_o[17]; endproperty
  a_bad: assert property (p_bad) else $error("bad value not flagged");
  property p_irq; mcu_int_o |-> status_o != 32'h0; endproperty
  a_irq: assert property (p_irq) else $error("pin without status");
  property p_rate; $rose(reset_n_i) |-> serial_bit_rate_o == reg_pkg::BIT_RATE_RESET; endproperty
  a_rate: assert property (p_rate) else $error("rate reset wrong");
endmodule
bind module_status_irq_regs status_irq_chk #(.TOP_RATE(TOP_RATE), .REL_MAJOR(REL_MAJOR),
  .REL_MINOR(REL_MINOR), .REL_PATCH(REL_PATCH)) u_chk (.mclk_i(mclk_i),
  .reset_n_i(reset_n_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o),
  .access_ok_i(access_ok_i), .data_ready_i(data_ready_i), .err_general_i(err_general_i),
  .fifo_fill_i(fifo_fill_i), .stream_en_o(stream_en_o), .serial_bit_rate_o(serial_bit_rate_o),
  .status_o(status_o), .mcu_int_o(mcu_int_o));

// ==== tb/tb_module_status_irq_regs.sv ====
`timescale 1ns/1ps
module tb_module_status_irq_regs;
  logic mclk_i = 1'b0, reset_n_i = 1'b0, buf_rd = 1'b0, ok = 1'b1;
  logic created = 1'b0, active = 1'b0, ready = 1'b0;
  logic wr, rd, rvalid, stream_en, mcu_int, cmd_valid;
  logic [31:0] cmd_code, sleep_val, status_q;
  logic [4:0] errs = 5'h00;
  logic [7:0] addr;
  logic [31:0] wdata, rdata, rate, rd_val, r, fill = 32'h0;
  logic [31:0] m_sticky = 32'h0, m_mask = 32'h0, m_pol = 32'h0, m_stream = 32'h0;
  logic [31:0] m_rate = reg_pkg::BIT_RATE_RESET;
  logic [7:0] ro [5] = '{8'h10, 8'h11, 8'h12, 8'he9, 8'h40};
  logic [31:0] ro_exp [5];
  int pos [$] = '{0, 1, 8, 16, 17, 18, 19, 20, 21};
  int bad_count = 0, samples_checked = 0;
  integer seed = 32'h2eed2cef;
  always #12.5 mclk_i = ~mclk_i;
  module_status_irq_regs u_dut (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .reg_wr_i(wr),
    .reg_rd_i(rd), .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
    .reg_rvalid_o(rvalid), .buf_rd_i(buf_rd), .access_ok_i(ok), .svc_created_i(created),
    .svc_active_i(active), .data_ready_i(ready), .err_general_i(errs[0]),
    .err_bad_cmd_i(errs[1]), .err_bad_mode_i(errs[2]), .err_create_i(errs[3]),
    .err_activate_i(errs[4]), .fifo_fill_i(fill), .stream_en_o(stream_en),
    .serial_bit_rate_o(rate), .sleep_setting_o(sleep_val), .cmd_valid_o(cmd_valid),
    .cmd_code_o(cmd_code), .status_o(status_q), .mcu_int_o(mcu_int));
  host_mcu u_host (.mclk_i(mclk_i), .reg_wr_o(wr), .reg_rd_o(rd), .reg_addr_o(addr),
    .reg_wdata_o(wdata), .reg_rdata_i(rdata), .reg_rvalid_i(rvalid));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic logic [31:0] m_status();
    return m_sticky | {23'h0, ready, 6'h0, active, created};
  endfunction
  task automatic tick(input int n);
    repeat (n) @(posedge mclk_i);
  endtask
  task automatic mr(input logic [7:0] a, input logic [31:0] exp);
    u_host.rd(a, rd_val);
    chk(rd_val, exp);
  endtask
  task automatic mw(input logic [7:0] a, input logic [31:0] d);
    if (a inside {8'h05, 8'h07, 8'h08, 8'h09, 8'h0a} && !ok) m_sticky[21] = 1'b1;
    else if ((a == 8'h05 || a == 8'h09) && d > 1) m_sticky[17] = 1'b1;
    else if (a == 8'h07 && (d == 0 || d > reg_pkg::TOP_RATE_DEFAULT)) m_sticky[17] = 1'b1;
    else if (a == 8'h05) m_stream = d;
    else if (a == 8'h07) m_rate = d;
    else if (a == 8'h08) m_mask = d;
    else if (a == 8'h09) m_pol = d;
    else if (a == 8'h03 && d == 32'h4) m_sticky = 32'h0;
    u_host.wr(a, d);
  endtask
  task automatic pulse(input logic [4:0] v);
    @(posedge mclk_i) errs <= v;
    @(posedge mclk_i) errs <= 5'h00;
    m_sticky[20:16] = m_sticky[20:16] | v;
  endtask
  task automatic ci();
    tick(3);
    #1;
    chk({31'h0, mcu_int}, {31'h0, m_pol == 32'h1 && (m_status() & m_mask) != 0});
    chk(status_q, m_status());
  endtask
  task automatic complete_run();
    $display("compares %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    #100000;
    bad_count++;
    complete_run();
  end
  initial begin
    tick(4);
    reset_n_i <= 1'b1;
    fill <= $random(seed);
    tick(1);
    #1;
    chk(rate, reg_pkg::BIT_RATE_RESET);
    ro_exp = '{reg_pkg::PART_CODE_DEFAULT, {8'h00, reg_pkg::REL_MAJOR_DEFAULT,
      reg_pkg::REL_MINOR_DEFAULT, reg_pkg::REL_PATCH_DEFAULT}, reg_pkg::TOP_RATE_DEFAULT, fill, 0};
    foreach (ro[i]) begin
      mw(ro[i], $random(seed));
      mr(ro[i], ro_exp[i]);
    end
    repeat (4) begin
      @(posedge mclk_i) {created, active, ready} <= 3'($random(seed));
      tick(2);
      mr(8'h06, m_status());
    end
    foreach (pos[i]) if (i < 3) begin
      mw(8'h05, i == 2 ? 32'h2 : 32'h1 - i);
      tick(2);
      #1;
      chk({31'h0, stream_en}, m_stream);
    end
    @(posedge mclk_i) ok <= 1'b0;
    // let the access level settle before the model reads it
    #1;
    mw(8'h05, 32'h1);
    @(posedge mclk_i) buf_rd <= 1'b1;
    @(posedge mclk_i) buf_rd <= 1'b0;
    ok <= 1'b1;
    tick(2);
    mr(8'h06, m_status());
    for (int k = 0; k < 5; k++) begin
      pulse(5'h01 << k);
      mr(8'h06, m_status());
    end
    mw(8'h03, 32'h4);
    mr(8'h06, m_status());
    mw(8'h03, 32'h7);
    #1;
    chk({31'h0, cmd_valid}, 32'h1);
    chk(cmd_code, 32'h7);
    mw(8'h0a, 32'h3);
    mr(8'h0a, 32'h3);
    chk(sleep_val, 32'h3);
    @(posedge mclk_i) {created, active, ready} <= 3'b101;
    pulse(5'($random(seed)));
    mw(8'h09, 32'h1);
    foreach (pos[i]) begin
      mw(8'h08, 32'h1 << pos[i]);
      ci();
    end
    mr(8'h06, m_status());
    mw(8'h08, 32'h0);
    ci();
    mw(8'h08, 32'hffff_ffff);
    mw(8'h09, 32'h0);
    ci();
    mw(8'h09, 32'h1);
    ci();
    r = ({$random(seed)} % reg_pkg::TOP_RATE_DEFAULT) + 1;
    mw(8'h07, r);
    mr(8'h07, m_rate);
    mw(8'h07, reg_pkg::TOP_RATE_DEFAULT + 1);
    mr(8'h07, m_rate);
    mr(8'h06, m_status());
    complete_run();
  end
endmodule
